// ===== include/csbc_pkg.sv
// Package: constants and types for the processor address/command port
package csbc_pkg;
  localparam int ADDR_HI = 39;
  localparam int ADDR_LO = 4;
  localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
  localparam int CMD_W = 4;
  localparam int FLASH_W = 8;
  localparam int ISO_W = 3;

  // Inbound commands from the processor
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_LOCK = 4'h1;
  localparam logic [3:0] CMD_FETCH = 4'h2;
  localparam logic [3:0] CMD_FETCH_M = 4'h3;
  localparam logic [3:0] CMD_MB = 4'h4;
  localparam logic [3:0] CMD_SET_DIRTY = 4'h5;
  localparam logic [3:0] CMD_WR_BLK = 4'h6;
  localparam logic [3:0] CMD_WR_BLK_LOCK = 4'h7;
  localparam logic [3:0] CMD_RD_MISS0 = 4'h8;
  localparam logic [3:0] CMD_RD_MISS1 = 4'h9;
  localparam logic [3:0] CMD_RD_MOD0 = 4'ha;
  localparam logic [3:0] CMD_RD_MOD1 = 4'hb;
  localparam logic [3:0] CMD_L3_VICTIM = 4'hc;
  localparam logic [3:0] CMD_UNUSED = 4'hd;
  localparam logic [3:0] CMD_RD_MOD_SC0 = 4'he;
  localparam logic [3:0] CMD_RD_MOD_SC1 = 4'hf;

  // Outbound commands to the processor
  localparam logic [3:0] OCMD_IDLE = 4'h0;
  localparam logic [3:0] OCMD_FLUSH = 4'h1;
  localparam logic [3:0] OCMD_INVAL = 4'h2;
  localparam logic [3:0] OCMD_READ = 4'h4;

  // Probe status codes
  localparam logic [1:0] PRB_NOP = 2'h0;
  localparam logic [1:0] PRB_MISS = 2'h1;
  localparam logic [1:0] PRB_SCACHE = 2'h2;
  localparam logic [1:0] PRB_L3 = 2'h3;

  localparam logic [3:0] CLS_NONE = 4'h0;
  localparam logic [3:0] CLS_LOCK = 4'h1;
  localparam logic [3:0] CLS_BARRIER = 4'h2;
  localparam logic [3:0] CLS_WRITE = 4'h3;
  localparam logic [3:0] CLS_READ = 4'h4;
  localparam logic [3:0] CLS_READ_MOD = 4'h5;
  localparam logic [3:0] CLS_READ_MOD_SC = 4'h6;
  localparam logic [3:0] CLS_VICTIM = 4'h7;

  typedef enum logic [1:0] {
    CSBC_IDLE = 2'b00,
    CSBC_REQ = 2'b01,
    CSBC_DRIVE = 2'b10,
    CSBC_RELEASE = 2'b11
  } csbc_state_e;
endpackage : csbc_pkg

// ===== rtl/csbc_cmd_decode.sv
// Inbound processor command decoder
`timescale 1ns/10ps
module csbc_cmd_decode (
  // Command in
  input wire logic [csbc_pkg::CMD_W-1:0] cmd,
  // Decode out
  output logic [3:0] cls,
  output logic take_action,
  output logic needs_ack
);
  import csbc_pkg::*;

  always_comb begin
    cls = CLS_NONE;
    take_action = 1'b1;
    needs_ack = 1'b1;
    case (cmd)
      CMD_LOCK: cls = CLS_LOCK;
      CMD_MB: cls = CLS_BARRIER;
      CMD_WR_BLK, CMD_WR_BLK_LOCK: cls = CLS_WRITE;
      CMD_RD_MISS0, CMD_RD_MISS1: cls = CLS_READ;
      CMD_RD_MOD0, CMD_RD_MOD1: cls = CLS_READ_MOD; // see RQ8
      CMD_RD_MOD_SC0, CMD_RD_MOD_SC1: cls = CLS_READ_MOD_SC; // see RQ11
      CMD_L3_VICTIM: cls = CLS_VICTIM;
      CMD_FETCH, CMD_FETCH_M, CMD_SET_DIRTY: begin
        take_action = 1'b0; // see RQ9
      end
      CMD_IDLE, CMD_UNUSED: begin
        take_action = 1'b0; // see RQ10
        needs_ack = 1'b0;
      end
      default: begin
        take_action = 1'b0;
        needs_ack = 1'b0;
      end
    endcase
  end
endmodule : csbc_cmd_decode

// ===== rtl/csbc_port.sv
// Processor address/command port of the core logic
// Functional notes
// RQ1: Request bus one cycle before driving it
// RQ2: Odd parity over address and command
// RQ3: Parity driven during flash access too
// RQ4: Flash signals share low address lines
// RQ5: Processor returns two-bit probe status
// RQ6: Probe codes 00,01,10,11 nop/miss/scache/l3
// RQ7: Acknowledge only when command can be taken
// RQ8: Decode inbound four-bit command codes
// RQ9: Fetch, fetch-modify, set-dirty acknowledged, ignored
// RQ10: Code 1101 handled as idle
// RQ11: Store-conditional read-modify variants recognised
// RQ12: Outbound only idle, flush, invalidate, read
// RQ13: Power-control output requests processor power-down
// RQ14: Active-low processor reset under device control
// RQ15: Three isolation outputs decouple the cache
// RQ16: Substitute clock supplied while processor off; this port has no clock output
`timescale 1ns/10ps
module csbc_port #(
  parameter int FLASH_LINES = csbc_pkg::FLASH_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Shared address/command bus
  input wire logic [csbc_pkg::ADDR_W-1:0] addr_in,
  output logic [csbc_pkg::ADDR_W-1:0] addr_out,
  output logic addr_oe,
  input wire logic [csbc_pkg::CMD_W-1:0] cmd_in,
  output logic [csbc_pkg::CMD_W-1:0] cmd_out,
  output logic cmd_oe,
  input wire logic par_in,
  output logic par_out,
  output logic par_oe,
  output logic addr_bus_req,
  output logic cmd_ack,
  input wire logic [1:0] probe_status,
  // Processor control
  output logic cpu_pwr_down,
  output logic cpu_reset_n,
  output logic [csbc_pkg::ISO_W-1:0] cache_isolate,
  // Core side: outbound command request
  input wire logic out_req,
  input wire logic [csbc_pkg::CMD_W-1:0] out_cmd,
  input wire logic [csbc_pkg::ADDR_W-1:0] out_addr,
  output logic out_busy,
  // Core side: flash path
  input wire logic flash_req,
  input wire logic [FLASH_LINES-1:0] flash_sig,
  // Core side: inbound command stream
  input wire logic core_ready,
  output logic in_valid,
  output logic [3:0] in_class,
  output logic [csbc_pkg::ADDR_W-1:0] in_addr,
  output logic in_par_err,
  output logic probe_valid,
  output logic [1:0] probe_code,
  input wire logic probe_expect,
  // Core side: processor control
  input wire logic pwr_down_req,
  input wire logic cpu_reset_req,
  input wire logic isolate_req
);
  import csbc_pkg::*;

  logic rst_s1_reg;
  logic rst_s2_reg;
  csbc_state_e state_reg;
  csbc_state_e state_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [CMD_W-1:0] cmd_reg;
  logic flash_mode_reg;
  logic [FLASH_LINES-1:0] flash_reg;
  logic [3:0] cls;
  logic take_action;
  logic needs_ack;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  csbc_cmd_decode u_dec (
    .cmd(cmd_in),
    .cls(cls),
    .take_action(take_action),
    .needs_ack(needs_ack)
  );

  // Outbound codes outside the legal set degrade to idle
  wire out_cmd_legal = (out_cmd == OCMD_IDLE) || (out_cmd == OCMD_FLUSH) ||
                       (out_cmd == OCMD_INVAL) || (out_cmd == OCMD_READ); // see RQ12
  wire [CMD_W-1:0] out_cmd_safe = out_cmd_legal ? out_cmd : OCMD_IDLE;
  wire start = (state_reg == CSBC_IDLE) && (out_req || flash_req);
  wire inbound_ok = (state_reg == CSBC_IDLE) && !out_req && !flash_req;

  // Flash signals replace the low address lines in flash mode
  wire [ADDR_W-1:0] flash_addr = {addr_reg[ADDR_W-1:FLASH_LINES], flash_reg}; // see RQ4
  wire [ADDR_W-1:0] drv_addr = flash_mode_reg ? flash_addr : addr_reg;
  wire [CMD_W-1:0] drv_cmd = flash_mode_reg ? OCMD_IDLE : cmd_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CSBC_IDLE: if (start) state_next = CSBC_REQ;
      CSBC_REQ: state_next = CSBC_DRIVE; // see RQ1
      CSBC_DRIVE: state_next = CSBC_RELEASE;
      CSBC_RELEASE: state_next = CSBC_IDLE;
      default: state_next = CSBC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      state_reg <= CSBC_IDLE;
      addr_reg <= '0;
      cmd_reg <= OCMD_IDLE;
      flash_mode_reg <= 1'b0;
      flash_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (start) begin
        flash_mode_reg <= flash_req && !out_req;
        addr_reg <= out_addr;
        cmd_reg <= out_cmd_safe;
        flash_reg <= flash_sig;
      end
    end
  end

  // Request rises in REQ, the cycle before the bus is driven
  always_ff @(posedge mclk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      addr_bus_req <= 1'b0;
      addr_oe <= 1'b0;
      cmd_oe <= 1'b0;
      par_oe <= 1'b0;
      addr_out <= '0;
      cmd_out <= '0;
      par_out <= 1'b1;
    end else begin
      addr_bus_req <= start; // see RQ1
      addr_oe <= (state_next == CSBC_DRIVE);
      cmd_oe <= (state_next == CSBC_DRIVE);
      par_oe <= (state_next == CSBC_DRIVE); // see RQ3
      addr_out <= drv_addr;
      cmd_out <= drv_cmd;
      par_out <= ~(^{drv_addr, drv_cmd}); // see RQ2
    end
  end

  // Inbound accept, parity check and probe capture
  // A command still held in its acknowledge cycle is not taken twice
  wire in_take = inbound_ok && needs_ack && core_ready && !cmd_ack; // see RQ7
  wire in_par_bad = ~(^{addr_in, cmd_in, par_in}); // see RQ2
  always_ff @(posedge mclk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      cmd_ack <= 1'b0;
      in_valid <= 1'b0;
      in_class <= CLS_NONE;
      in_addr <= '0;
      in_par_err <= 1'b0;
      probe_valid <= 1'b0;
      probe_code <= PRB_NOP;
    end else begin
      cmd_ack <= in_take;
      in_valid <= in_take && take_action;
      if (in_take) begin
        in_class <= cls;
        in_addr <= addr_in;
        in_par_err <= in_par_bad;
      end
      probe_valid <= probe_expect && (probe_status != PRB_NOP); // see RQ6
      if (probe_expect) probe_code <= probe_status; // see RQ5
    end
  end

  // Processor power, reset and isolation controls
  always_ff @(posedge mclk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      cpu_pwr_down <= 1'b0;
      cpu_reset_n <= 1'b0;
      cache_isolate <= '0;
    end else begin
      cpu_pwr_down <= pwr_down_req; // see RQ13
      cpu_reset_n <= ~cpu_reset_req; // see RQ14
      cache_isolate <= {ISO_W{isolate_req}}; // see RQ15
    end
  end

  assign out_busy = (state_reg != CSBC_IDLE);
endmodule : csbc_port

// ===== tb/csbc_port_chk.sv
// Assertion checker for the address/command port
`timescale 1ns/10ps
module csbc_chk
  import csbc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus and core side
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic addr_oe,
  input wire logic [CMD_W-1:0] cmd_in,
  input wire logic [CMD_W-1:0] cmd_out,
  input wire logic par_out,
  input wire logic par_oe,
  input wire logic addr_bus_req,
  input wire logic cmd_ack,
  input wire logic core_ready,
  input wire logic in_valid
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_req_lead: assert property ($rose(addr_oe) |-> $past(addr_bus_req))
    else $error("drive without request");
  a_req_then_oe: assert property (addr_bus_req |=> addr_oe && !addr_bus_req)
    else $error("no drive after request");
  a_odd_parity: assert property (addr_oe |-> ^{addr_out, cmd_out, par_out})
    else $error("parity not odd");
  a_par_driven: assert property (addr_oe |-> par_oe)
    else $error("parity floats");
  a_out_legal: assert property (addr_oe |-> cmd_out inside {4'h0, 4'h1, 4'h2, 4'h4})
    else $error("bad outbound code");
  a_ack_ready: assert property (cmd_ack |-> $past(core_ready))
    else $error("ack while not ready");
  a_ack_single: assert property (cmd_ack |=> !cmd_ack)
    else $error("command acked twice");
  a_idle_noack: assert property (cmd_ack |-> !($past(cmd_in) inside {4'h0, 4'hd}))
    else $error("idle code acked");
  a_fetch_quiet: assert property ((cmd_ack && ($past(cmd_in) inside {4'h2, 4'h3, 4'h5}))
    |-> !in_valid)
    else $error("ignored code passed on");
endmodule : csbc_chk

bind csbc_port csbc_chk i_csbc_chk (.mclk, .rst_n, .addr_out, .addr_oe, .cmd_in, .cmd_out,
  .par_out, .par_oe, .addr_bus_req, .cmd_ack, .core_ready, .in_valid);

// ===== tb/csbc_cpu_model.sv
// Processor model: sends commands and answers probes
`timescale 1ns/10ps
module csbc_cpu_model
  import csbc_pkg::*;
(
  // Clock and answer
  input wire logic mclk,
  input wire logic cmd_ack,
  // Processor drive
  output logic [ADDR_W-1:0] m_addr,
  output logic [CMD_W-1:0] m_cmd,
  output logic m_par,
  output logic [1:0] probe_status
);
  initial begin
    {m_addr, m_cmd, probe_status} = '0;
    m_par = 1'b1;
  end
  // Held until acknowledged or for at most eight cycles; a set bad flag breaks the parity
  task automatic send(input logic [3:0] c, input logic [ADDR_W-1:0] a, input logic bad,
    output logic ok);
    ok = 1'b0;
    m_addr <= a;
    m_cmd <= c;
    m_par <= ~^{a, c} ^ bad;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge mclk);
      ok = cmd_ack;
    end
    // Released address shows the inverse of its last value
    m_addr <= ~a;
    m_cmd <= CMD_IDLE;
    m_par <= ~^{~a, CMD_IDLE};
  endtask : send
  task automatic probe(input logic [1:0] s);
    probe_status <= s;
  endtask : probe
endmodule : csbc_cpu_model

// ===== tb/cpu_system_bus_command_port_tb.sv
// Self-checking bench for the address/command port
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module cpu_system_bus_command_port_tb;
  import csbc_pkg::*;
  logic [ADDR_W-1:0] addr_in, addr_out, out_addr, in_addr, m_addr, a, ia;
  logic [3:0] cmd_in, cmd_out, out_cmd, in_class, m_cmd, k, cc;
  logic [7:0] flash_sig;
  logic [2:0] cache_isolate;
  logic [1:0] probe_status, probe_code;
  logic mclk, rst_n, par_in, par_out, par_oe, addr_oe, cmd_oe, addr_bus_req, cmd_ack;
  logic in_valid, in_par_err, probe_valid, cpu_pwr_down, cpu_reset_n, m_par, out_busy;
  logic out_req, flash_req, core_ready, probe_expect, pwr_down_req, cpu_reset_req;
  logic isolate_req, ok, fl, vc, pe, ev, bad;
  integer seed, n, fails = 0, n_checks = 0;
  assign addr_in = addr_oe ? addr_out : m_addr;
  assign cmd_in = cmd_oe ? cmd_out : m_cmd;
  assign par_in = par_oe ? par_out : m_par;
  csbc_port i_csbc_port (.*);
  csbc_cpu_model i_csbc_cpu_model (.*);
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (cmd_ack) {vc, cc, pe, ia} <= {in_valid, in_class, in_par_err, in_addr};
  function automatic logic [3:0] ecls(input logic [3:0] c);
    case (c)
      4'h1: return CLS_LOCK;
      4'h4: return CLS_BARRIER;
      4'h6, 4'h7: return CLS_WRITE;
      4'h8, 4'h9: return CLS_READ;
      4'ha, 4'hb: return CLS_READ_MOD;
      4'hc: return CLS_VICTIM;
      4'he, 4'hf: return CLS_READ_MOD_SC;
      default: return CLS_NONE;
    endcase
  endfunction : ecls
  task automatic final_report;
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    {mclk, rst_n, out_req, flash_req, core_ready, probe_expect, out_cmd, out_addr} = '0;
    {flash_sig, pwr_down_req, cpu_reset_req, isolate_req} = '0;
    seed = 32'h70b7dc33;
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    repeat (3) @(posedge mclk);
    // Every code once, then random ones, some with broken parity, last one not ready
    for (int c = 0; c < 40; c++) begin
      k = c < 16 ? 4'(c) : 4'($random(seed));
      bad = c > 16 && c[0];
      ev = !(k inside {4'h2, 4'h3, 4'h5});
      core_ready <= c != 39;
      a = 36'({$random(seed), $random(seed)});
      i_csbc_cpu_model.send(k, a, bad, ok);
      repeat (2) @(posedge mclk);
      `CHK(ok, !(k inside {4'h0, 4'hd}) && c != 39)
      if (ok) `CHK({vc, vc ? cc : CLS_NONE, pe, ia}, {ev, ecls(k), bad, a})
    end
    core_ready <= 1;
    for (int c = 0; c < 20; c++) begin
      k = c < 16 ? 4'(c) : 4'($random(seed));
      a = 36'({$random(seed), $random(seed)});
      fl = c > 15;
      out_req <= !fl;
      flash_req <= fl;
      out_cmd <= k;
      out_addr <= a;
      flash_sig <= a[7:0];
      @(posedge mclk);
      out_req <= 0;
      flash_req <= 0;
      k = k inside {4'h0, 4'h1, 4'h2, 4'h4} ? k : OCMD_IDLE;
      n = 0;
      while (!addr_oe && n < 8) begin
        @(posedge mclk);
        n++;
      end
      if (n == 8) begin
        fails++;
        final_report();
      end
      `CHK({out_busy, cmd_oe, par_oe, addr_bus_req}, 4'he)
      if (fl) `CHK({cmd_out, addr_out[7:0]}, {OCMD_IDLE, a[7:0]})
      else `CHK({cmd_out, addr_out}, {k, a})
      repeat (3) @(posedge mclk);
      `CHK({out_busy, addr_oe}, 2'h0)
    end
    probe_expect <= 1;
    for (int c = 0; c < 4; c++) begin
      i_csbc_cpu_model.probe(2'(c));
      repeat (2) @(posedge mclk);
      `CHK({probe_valid, probe_code & {2{probe_valid}}}, {c != 0, 2'(c)})
    end
    {pwr_down_req, cpu_reset_req, isolate_req} <= 3'h7;
    repeat (4) @(posedge mclk);
    `CHK({cpu_pwr_down, cpu_reset_n, cache_isolate}, 5'h17)
    {pwr_down_req, cpu_reset_req, isolate_req} <= 3'h0;
    repeat (4) @(posedge mclk);
    `CHK({cpu_pwr_down, cpu_reset_n, cache_isolate}, 5'h08)
    final_report();
  end
endmodule : cpu_system_bus_command_port_tb
